// ===== watchdog_control_unit.sv
// Contract
// - With interrupt select set, expiry raises an interrupt, not reset.
// - The timeout interrupt is high priority, never masked globally.
// - Unsupervised, the unit runs as interval timer, interrupting each period.
// - The timeout period follows the prescale field.
// - Every timeout sets the event flag.
// - Writing zero or hardware reset clears the event flag.
// - Setting enable starts the watchdog and clears its counters.
// - Enabled and unserviced, expiry gives reset or interrupt per select.
//
`timescale 1ns/100ps
`include "watchdog_params.svh"

module watchdog_control_unit
   import watchdog_pkg::*;
#(
   parameter int TICK_CYCLES = `WDT_TICK_CYCLES,
   parameter int PERIOD_W = `WDT_PERIOD_WIDTH
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wr_data_i,
   input wire logic instr_start_i,
   output logic [7:0] reg_rd_data_o,
   output logic timeout_irq_o,
   output logic timeout_reset_o,
   output logic prescale_reserved_o
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   watchdog_control_t ctrl_reg;
   watchdog_control_t ctrl_next;
   watchdog_control_t wr_data;
   guard_state_t guard_reg;
   guard_state_t guard_next;
   logic irq_reg;
   logic irq_next;
   logic reset_reg;
   logic reset_next;
   logic reserved_reg;
   logic reserved_next;
   logic write_ok;
   logic unlock_req;
   logic clear_cnt;
   logic run_cnt;
   logic expire;
   logic [3:0] upd_prescale;
   logic upd_select;
   logic upd_enable;
   logic flag_clear;
   logic service;
   watchdog_control_t rd_image;

   assign wr_data = watchdog_control_t'(reg_wr_data_i);

   // ****************************************************************
   // Write guard
   // ****************************************************************
   // A write is taken only while the guard is open; any other write can
   // do nothing but open the guard by carrying the unlock bit.
   always_comb begin
      write_ok = reg_wr_i && (guard_reg != GUARD_LOCKED);
      unlock_req = reg_wr_i && !write_ok && wr_data.guard_write_unlock;
      guard_next = guard_reg;
      unique case (guard_reg)
         GUARD_LOCKED: begin
            if (unlock_req) begin
               guard_next = GUARD_ARMED;
            end
         end
         GUARD_ARMED: begin
            if (write_ok) begin
               guard_next = GUARD_LOCKED;
            end else if (instr_start_i) begin
               guard_next = GUARD_NEXT;
            end
         end
         GUARD_NEXT: begin
            // The instruction after the unlock started; a second start
            // without a write closes the guard again.
            if (write_ok) begin
               guard_next = GUARD_LOCKED;
            end else if (instr_start_i) begin
               guard_next = GUARD_LOCKED;
            end
         end
         default: begin
            guard_next = GUARD_LOCKED;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         guard_reg <= GUARD_LOCKED;
      end else begin
         guard_reg <= guard_next;
      end
   end

   // ****************************************************************
   // Write decode
   // ****************************************************************
   // The prescale, select and enable fields of a write are split out first,
   // so the update below holds one plain assignment for each of them.
   always_comb begin
      upd_prescale = wr_data.timeout_prescale;
      upd_select = wr_data.timeout_irq_select;
      upd_enable = wr_data.guard_enable;
      // Writing one to the flag leaves it alone; writing zero clears it.
      flag_clear = write_ok && !wr_data.timeout_event_flag;
      // Each accepted write with enable set restarts the count.
      service = write_ok && wr_data.guard_enable;
   end

   // ****************************************************************
   // Control register
   // ****************************************************************
   always_comb begin
      ctrl_next = ctrl_reg;
      clear_cnt = service;
      if (write_ok) begin
         ctrl_next.timeout_prescale = upd_prescale;
         ctrl_next.timeout_irq_select = upd_select;
         ctrl_next.guard_enable = upd_enable;
      end
      if (flag_clear) begin
         ctrl_next.timeout_event_flag = 1'b0;
      end
      // A timeout in the same cycle as a clearing write keeps the flag.
      if (expire) begin
         ctrl_next.timeout_event_flag = 1'b1;
      end
      ctrl_next.guard_write_unlock = (guard_next != GUARD_LOCKED);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= watchdog_control_t'(`WDT_CTRL_RESET);
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ****************************************************************
   // Read-back
   // ****************************************************************
   // The unlock bit reads back the guard itself, so software can see
   // whether its next write will be taken.
   always_comb begin
      rd_image = ctrl_reg;
      rd_image.guard_write_unlock = (guard_reg != GUARD_LOCKED);
   end

   assign reg_rd_data_o = rd_image;

   // ****************************************************************
   // Timeout counter
   // ****************************************************************
   // A reserved prescale code halts the count so that no timeout of an
   // undefined length is ever produced.
   assign run_cnt = ctrl_reg.guard_enable && !reserved_reg;

   timeout_counter #(
      .TICK_CYCLES(TICK_CYCLES),
      .PERIOD_W(PERIOD_W)
   ) u_timeout_counter (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .clear_i(clear_cnt),
      .run_i(run_cnt),
      .prescale_i(ctrl_reg.timeout_prescale),
      .expire_o(expire)
   );

   // ****************************************************************
   // Expiry actions
   // ****************************************************************
   // The interrupt line bypasses the global interrupt enable entirely.
   always_comb begin
      irq_next = expire && ctrl_reg.timeout_irq_select;
      reset_next = expire && !ctrl_reg.timeout_irq_select;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_reg <= 1'b0;
         reset_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
         reset_reg <= reset_next;
      end
   end

   // ****************************************************************
   // Reserved prescale codes
   // ****************************************************************
   // The flag follows the register's next value, so it rises on the
   // same clock edge that stores a reserved code in the register.
   always_comb begin
      reserved_next =
         (ctrl_next.timeout_prescale > `WDT_PRESCALE_MAX);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reserved_reg <= 1'b0;
      end else begin
         reserved_reg <= reserved_next;
      end
   end

   assign timeout_irq_o = irq_reg;
   assign timeout_reset_o = reset_reg;
   assign prescale_reserved_o = reserved_reg;

endmodule

// ===== watchdog_params.svh
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

// ****************************************************************
// Control register field positions
// ****************************************************************
`define WDT_CTRL_WIDTH 8
`define WDT_PRESCALE_MSB 7
`define WDT_PRESCALE_LSB 4
`define WDT_IRQ_SELECT_BIT 3
`define WDT_EVENT_FLAG_BIT 2
`define WDT_ENABLE_BIT 1
`define WDT_UNLOCK_BIT 0
`define WDT_CTRL_RESET 8'h00

// ****************************************************************
// Prescaler codes
// ****************************************************************
`define WDT_PRESCALE_MAX 4'h9

// ****************************************************************
// Timing
// ****************************************************************
`define WDT_CLK_PERIOD_NS 100
`define WDT_TICK_NS 1000
`define WDT_TICK_CYCLES ((`WDT_TICK_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)
`define WDT_PERIOD_WIDTH 10

`endif

// ===== watchdog_pkg.sv
package watchdog_pkg;

   // Control register image, most significant field first.
   typedef struct packed {
      logic [3:0] timeout_prescale;
      logic timeout_irq_select;
      logic timeout_event_flag;
      logic guard_enable;
      logic guard_write_unlock;
   } watchdog_control_t;

   // Write guard sequence.
   typedef enum logic [2:0] {
      GUARD_LOCKED = 3'b001,
      GUARD_ARMED = 3'b010,
      GUARD_NEXT = 3'b100
   } guard_state_t;

endpackage

// ===== timeout_counter.sv
`timescale 1ns/100ps
`include "watchdog_params.svh"

module timeout_counter
   import watchdog_pkg::*;
#(
   parameter int TICK_CYCLES = `WDT_TICK_CYCLES,
   parameter int PERIOD_W = `WDT_PERIOD_WIDTH
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   input wire logic run_i,
   input wire logic [3:0] prescale_i,
   output logic expire_o
);

   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   logic [TW-1:0] tick_cnt_reg;
   logic [TW-1:0] tick_cnt_next;
   logic [PERIOD_W-1:0] period_cnt_reg;
   logic [PERIOD_W-1:0] period_cnt_next;
   logic expire_reg;
   logic expire_next;
   logic [PERIOD_W-1:0] period_last;

   // ****************************************************************
   // Period counter
   // ****************************************************************
   always_comb begin
      period_last = (PERIOD_W'(1) << prescale_i) - PERIOD_W'(1);
      tick_cnt_next = tick_cnt_reg;
      period_cnt_next = period_cnt_reg;
      expire_next = 1'b0;
      if (clear_i || !run_i) begin
         tick_cnt_next = '0;
         period_cnt_next = '0;
      end else if (tick_cnt_reg == TICK_LAST) begin
         tick_cnt_next = '0;
         if (period_cnt_reg >= period_last) begin
            // The count restarts so the timer repeats as an interval timer.
            period_cnt_next = '0;
            expire_next = 1'b1;
         end else begin
            period_cnt_next = period_cnt_reg + PERIOD_W'(1);
         end
      end else begin
         tick_cnt_next = tick_cnt_reg + TW'(1);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_reg <= '0;
         period_cnt_reg <= '0;
         expire_reg <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
         period_cnt_reg <= period_cnt_next;
         expire_reg <= expire_next;
      end
   end

   assign expire_o = expire_reg;

endmodule

// ===== watchdog_properties.sv
`timescale 1ns/100ps
module watchdog_properties (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wr_data_i,
   input wire logic [7:0] reg_rd_data_o,
   input wire logic timeout_irq_o,
   input wire logic timeout_reset_o,
   input wire logic prescale_reserved_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire ev = timeout_irq_o | timeout_reset_o;
   a_flag_on_event: assert property (ev |-> reg_rd_data_o[2])
      else $error("flag missing");
   a_irq_needs_sel: assert property
      (timeout_irq_o |-> $past(reg_rd_data_o[3]))
      else $error("irq without select");
   a_rst_needs_nosel: assert property
      (timeout_reset_o |-> !$past(reg_rd_data_o[3])) else $error("bad reset");
   a_single_pulse: assert property (ev |=> !ev)
      else $error("long pulse");
   a_flag_sticky: assert property
      (reg_rd_data_o[2] && !reg_wr_i |=> reg_rd_data_o[2])
      else $error("flag lost");
   a_flag_cause: assert property ($rose(reg_rd_data_o[2]) |-> ev)
      else $error("flag without event");
   a_locked_ignore: assert property
      (reg_wr_i && !reg_rd_data_o[0] && !reg_wr_data_i[0] |=>
      reg_rd_data_o[7:3] == $past(reg_rd_data_o[7:3]))
      else $error("locked write");
   a_reserved_quiet: assert property (prescale_reserved_o [*2] |-> !ev)
      else $error("reserved code expired");
   cover property (timeout_irq_o);
   cover property (timeout_reset_o);
   cover property (prescale_reserved_o);
   cover property (reg_wr_i && reg_rd_data_o[0]);
endmodule

bind watchdog_control_unit watchdog_properties u_props (.clk_sys_i, .rst_n_i,
   .reg_wr_i, .reg_wr_data_i, .reg_rd_data_o, .timeout_irq_o,
   .timeout_reset_o, .prescale_reserved_o);

// ===== tb_watchdog_control_unit.sv
`timescale 1ns/100ps
module tb_watchdog_control_unit
   import watchdog_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic reg_wr_i = 1'b0;
   logic [7:0] reg_wr_data_i = 8'h00;
   logic instr_start_i = 1'b0;
   logic [7:0] reg_rd_data_o;
   logic timeout_irq_o;
   logic timeout_reset_o;
   logic prescale_reserved_o;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   // Each row: control word written, then the expected period in cycles.
   logic [23:0] rows [4] = '{24'h0A_0002, 24'h12_0004, 24'h3A_0010,
      24'h92_0400};
   watchdog_control_unit #(.TICK_CYCLES(2)) uut (.clk_sys_i, .rst_n_i,
      .reg_wr_i, .reg_wr_data_i, .instr_start_i, .reg_rd_data_o,
      .timeout_irq_o, .timeout_reset_o, .prescale_reserved_o);
   always #50 clk_sys_i = ~clk_sys_i;
   // ****************************************
   // Helper tasks
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b1;
      reg_wr_data_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask
   task automatic prog(input logic [7:0] d);
      wr(8'h01);
      wr(d);
   endtask
   task automatic wait_ev();
      n = 0;
      do begin
         tick(1);
         n++;
      end while (!(timeout_irq_o | timeout_reset_o) && n < 3000);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      watchdog_control_t r;
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      tick(1);
      chk({reg_rd_data_o, timeout_irq_o, timeout_reset_o}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         r = rows[i][23:16];
         prog(r);
         wait_ev();
         wait_ev();
         chk(16'(n), rows[i][15:0]);
         chk({timeout_irq_o, timeout_reset_o, reg_rd_data_o[2]},
            {r.timeout_irq_select, ~r.timeout_irq_select, 1'b1});
         prog(8'h00);
         $display("row %0d done", i);
      end
      tick(4);
      wr(8'h0A);
      tick(10);
      chk({8'h00, reg_rd_data_o}, 16'h0000);
      wr(8'h01);
      @(posedge clk_sys_i);
      instr_start_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      instr_start_i <= 1'b0;
      wr(8'h0A);
      chk({8'h00, reg_rd_data_o & 8'hFE}, 16'h0000);
      $display("guard done");
      prog(8'h9A);
      wait_ev();
      prog(8'h9A);
      chk({8'h00, reg_rd_data_o}, 16'h009A);
      wait_ev();
      chk({15'h0000, n >= 1023}, 16'h0001);
      $display("flag done");
      prog(8'hA2);
      tick(40);
      chk({reg_rd_data_o, 7'h00, prescale_reserved_o}, 16'hA201);
      $display("reserved done");
      prog(8'h0A);
      wait_ev();
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      tick(2);
      chk({reg_rd_data_o, timeout_irq_o, timeout_reset_o}, 16'h0000);
      @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      tick(3);
      chk({reg_rd_data_o, 5'h00, timeout_irq_o, timeout_reset_o,
         prescale_reserved_o}, 16'h0000);
      $display("reset done");
      finish_test();
   end
endmodule
